// ==== hdl/bcs_pkg.sv ====
/*
  Package for the breaker communication status logic: position codes,
  indicator codes, write action classes, timing counts and defaults.
  Assumes a single 20 MHz system clock and synchronous active-high reset.
*/
package bcs_pkg;

  // System clock rate in hertz.
  localparam longint CLK_HZ = 64'h0000_0000_0131_2D00;

  // Delay before the missing-breaker diagnostic, in seconds.
  localparam int NOT_PRESENT_DIAG_S = 10;

  // Cycle count of that delay.
  localparam longint NP_DIAG_CYCLES = CLK_HZ * NOT_PRESENT_DIAG_S;

  // Width of the diagnostic delay counter.
  localparam int NP_CNT_W = 28;

  // Half period of the flashing green indicator, in milliseconds.
  localparam int FLASH_HALF_MS = 500;

  // Cycle count of half a flash period.
  localparam longint FLASH_HALF_CYCLES = (CLK_HZ * FLASH_HALF_MS) / 1000;

  // Width of the flash counter.
  localparam int FLASH_CNT_W = 24;

  // Factory fieldbus station address.
  localparam logic [6:0] STATION_ADDR_RST = 7'h7E;

  // Width of the local data image address and data.
  localparam int IMG_AW = 8;
  localparam int IMG_DW = 16;

  // Width of the internal breaker bus node address.
  localparam int NODE_W = 3;

  // Width of the write action class code.
  localparam int ACT_W = 4;

  // Decoded breaker position.
  typedef enum logic [1:0]
  {
    POS_NOT_PRESENT  = 2'h0,
    POS_DISCONNECTED = 2'h1,
    POS_TEST         = 2'h2,
    POS_CONNECTED    = 2'h3
  } bcs_pos_type;

  // Colour of a two-colour status indicator.
  typedef enum logic [1:0]
  {
    LED_OFF   = 2'h0,
    LED_RED   = 2'h1,
    LED_GREEN = 2'h2
  } bcs_led_type;

  // Fieldbus write action classes.
  typedef enum logic [3:0]
  {
    ACT_SWITCH       = 4'h0,
    ACT_TRIP_RESET   = 4'h1,
    ACT_PROT_PARAM   = 4'h2,
    ACT_EXT_PROT     = 4'h3,
    ACT_TRIP_UNIT_LINK_INDICATOR_PARAM   = 4'h4,
    ACT_METER_PARAM  = 4'h5,
    ACT_MAINT_RESET  = 4'h6,
    ACT_FORCE_OUT    = 4'h7,
    ACT_STARTUP_XFER = 4'h8,
    ACT_WAVE_TRIG    = 4'h9,
    ACT_WAVE_READ    = 4'hA,
    ACT_THRESH_PARAM = 4'hB,
    ACT_SYS_TIME     = 4'hC,
    ACT_FREE_TEXT    = 4'hD,
    ACT_MINMAX_RESET = 4'hE,
    ACT_USER_OUTPUT  = 4'hF
  } bcs_act_type;

endpackage

// ==== hdl/bcs_np_diag.sv ====
/*
  Delayed missing-breaker diagnostic. Counts the time spent in the
  not-present position and raises the diagnostic after the full delay.
  Assumes the position input is already synchronised to i_clk_sys.
*/
`timescale 1ns/1ps
module bcs_np_diag
  import bcs_pkg::*;
#(
  parameter longint DELAY_CYCLES = NP_DIAG_CYCLES
)
(
  input  wire logic        i_clk_sys,    // System clock.
  input  wire logic        i_rst,        // Synchronous reset.
  input  wire bcs_pos_type i_pos,        // Next reported position.
  input  wire logic        i_test_seen,  // Test switch actuated.
  output logic             o_diag        // Not-present diagnostic.
);

  logic [NP_CNT_W-1:0] cnt_q;
  logic [NP_CNT_W-1:0] cnt_d;
  logic                diag_q;
  logic                diag_d;
  logic                absent;
  logic                expired;

  // Counting runs only while the breaker is about to be reported absent.
  // The count starts one cycle early, so it is held against the full delay.
  assign absent  = (i_pos == POS_NOT_PRESENT) && !i_test_seen;
  assign expired = (cnt_q >= NP_CNT_W'(DELAY_CYCLES));
  assign cnt_d   = !absent ? '0 :
                   (expired ? cnt_q : cnt_q + NP_CNT_W'(1));
  // A test switch before expiry clears the count so nothing is raised.
  assign diag_d  = absent && (diag_q || expired);

  // Counter and diagnostic flag.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      cnt_q  <= '0;
      diag_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      diag_q <= diag_d;
    end
  end

  assign o_diag = diag_q;

endmodule

// ==== hdl/bcs_status.sv ====
/*
  Status and access-control logic of the breaker fieldbus module.
  // Functional notes
  // - Decode one-hot switches into breaker position.
  // - Keep old position while no switch actuated.
  // - Front switch release reports not present immediately.
  // - Raise not-present diagnostic after ten seconds.
  // - Test switch before expiry cancels the diagnostic.
  // - Refuse fieldbus writes without write permit.
  // - Block switching, parameters, resets, forcing, startup.
  // - Allow waveform, threshold, time, text, minmax, output.
  // - Station address defaults to 126, configurable.
  // - Fieldbus indicator green only with class 1 traffic.
  // - Internal bus indicator off, red, flashing, green.
  // - Answer host reads from local data image.
  // - Route host writes to addressed internal node.
  Assumes pins arrive asynchronously and are synchronised here; host and
  internal bus strobes come from logic on i_clk_sys.
*/
`timescale 1ns/1ps
module bcs_status
  import bcs_pkg::*;
#(
  parameter longint DIAG_CYCLES = NP_DIAG_CYCLES,
  parameter longint FLASH_CYCLES = FLASH_HALF_CYCLES
)
(
  input  wire logic              i_clk_sys,        // System clock.
  input  wire logic              i_rst,            // Sync reset.
  input  wire logic              i_rear_position_switch,   // Pin.
  input  wire logic              i_middle_position_switch, // Pin.
  input  wire logic              i_front_position_switch,  // Pin.
  input  wire logic              i_write_permit_input,     // Pin.
  input  wire logic              i_addr_cfg_we,    // Load station addr.
  input  wire logic [6:0]        i_addr_cfg,       // New station addr.
  input  wire logic              i_class1_cyclic,  // Class 1 exchange.
  input  wire logic              i_ibus_fault,     // Internal bus fault.
  input  wire logic              i_ibus_any_node,  // Any node found.
  input  wire logic              i_ibus_core_node, // Meter or trip unit.
  input  wire logic              i_img_we,         // Image update.
  input  wire logic [IMG_AW-1:0] i_img_waddr,      // Image update addr.
  input  wire logic [IMG_DW-1:0] i_img_wdata,      // Image update data.
  input  wire logic              i_host_rd,        // Host read request.
  input  wire logic [IMG_AW-1:0] i_host_raddr,     // Host read addr.
  input  wire logic              i_host_wr,        // Host write request.
  input  wire bcs_act_type       i_host_act,       // Write action class.
  input  wire logic [NODE_W-1:0] i_host_node,      // Target node.
  input  wire logic [IMG_DW-1:0] i_host_wdata,     // Write data.
  output bcs_pos_type            o_pos,            // Reported position.
  output logic                   o_np_diag,        // Not-present diag.
  output logic [6:0]             o_station_addr,   // Station address.
  output bcs_led_type            o_fieldbus_led,   // Fieldbus indicator.
  output bcs_led_type            o_ibus_led,       // Internal indicator.
  output logic                   o_host_rvalid,    // Read answer valid.
  output logic [IMG_DW-1:0]      o_host_rdata,     // Read answer data.
  output logic                   o_host_wr_ack,    // Write accepted.
  output logic                   o_host_wr_refused,// Write refused.
  output logic                   o_ibus_wr,        // Internal write.
  output logic [NODE_W-1:0]      o_ibus_node,      // Internal node.
  output logic [IMG_DW-1:0]      o_ibus_wdata      // Internal data.
);

  // Allowed-while-protected action classes.
  function automatic logic act_allowed(input bcs_act_type a);
    unique case (a)
      ACT_WAVE_TRIG, ACT_WAVE_READ, ACT_THRESH_PARAM, ACT_SYS_TIME,
      ACT_FREE_TEXT, ACT_MINMAX_RESET, ACT_USER_OUTPUT:
        act_allowed = 1'b1;
      default:
        act_allowed = 1'b0;
    endcase
  endfunction

  logic [3:0]             s1_q;
  logic [3:0]             s2_q;
  logic [3:0]             pins;
  logic                   rear;
  logic                   mid;
  logic                   front;
  logic                   permit;
  bcs_pos_type            pos_q;
  bcs_pos_type            pos_d;
  logic                   front_q;
  logic [6:0]             addr_q;
  logic [FLASH_CNT_W-1:0] fl_cnt_q;
  logic [FLASH_CNT_W-1:0] fl_cnt_d;
  logic                   fl_ph_q;
  logic                   fl_wrap;
  logic [IMG_DW-1:0]      img_q [0:(1<<IMG_AW)-1];
  logic [IMG_DW-1:0]      rdata_q;
  logic                   rvalid_q;
  logic                   wr_ok;
  logic                   ack_q;
  logic                   ref_q;
  logic                   iwr_q;
  logic [NODE_W-1:0]      inode_q;
  logic [IMG_DW-1:0]      idata_q;
  bcs_led_type            fb_led_d;
  bcs_led_type            fb_led_q;
  bcs_led_type            ib_led_d;
  bcs_led_type            ib_led_q;

  // Two-stage synchronisers for the switch and permit pins.
  assign pins = {i_write_permit_input, i_front_position_switch,
                 i_middle_position_switch, i_rear_position_switch};
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
    end
    else
    begin
      s1_q <= pins;
      s2_q <= s1_q;
    end
  end

  assign rear   = s2_q[0];
  assign mid    = s2_q[1];
  assign front  = s2_q[2];
  assign permit = s2_q[3];

  // Position decode; one-hot patterns, or all switches open just after front release, define a new position.
  assign pos_d =
    ( rear && !mid && !front) ? POS_CONNECTED :
    (!rear &&  mid && !front) ? POS_TEST :
    (!rear && !mid &&  front) ? POS_DISCONNECTED :
    (front_q && !front && !rear && !mid) ? POS_NOT_PRESENT :
    pos_q;

  // Position register and front switch history.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      pos_q   <= POS_NOT_PRESENT;
      front_q <= 1'b0;
    end
    else
    begin
      pos_q   <= pos_d;
      front_q <= front;
    end
  end

  assign o_pos = pos_q;

  // Delayed diagnostic for a missing breaker. It watches the next position,
  // so the flag drops at the same edge at which the position leaves absent.
  bcs_np_diag #(
    .DELAY_CYCLES (DIAG_CYCLES)
  ) u_np_diag (
    .i_clk_sys   (i_clk_sys),
    .i_rst       (i_rst),
    .i_pos       (pos_d),
    .i_test_seen (mid),
    .o_diag      (o_np_diag)
  );

  // Station address with factory default.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      addr_q <= STATION_ADDR_RST;
    else if (i_addr_cfg_we)
      addr_q <= i_addr_cfg;
  end

  assign o_station_addr = addr_q;

  // Flash timebase for the internal bus indicator.
  assign fl_wrap  = (fl_cnt_q >= FLASH_CNT_W'(FLASH_CYCLES - 1));
  assign fl_cnt_d = fl_wrap ? '0 : fl_cnt_q + FLASH_CNT_W'(1);
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      fl_cnt_q <= '0;
      fl_ph_q  <= 1'b0;
    end
    else
    begin
      fl_cnt_q <= fl_cnt_d;
      fl_ph_q  <= fl_ph_q ^ fl_wrap;
    end
  end

  // Indicator colours.
  assign fb_led_d = i_class1_cyclic ? LED_GREEN : LED_RED;
  assign ib_led_d =
    i_ibus_fault     ? LED_RED :
    !i_ibus_any_node ? LED_OFF :
    i_ibus_core_node ? LED_GREEN :
    (fl_ph_q ? LED_GREEN : LED_OFF);

  // Indicator registers follow their inputs through reset as well, so the
  // lights keep showing the bus state while the rest of the block is held,
  // save a flashing internal bus light, which stays off while reset holds fl_ph_q at 0.
  always_ff @(posedge i_clk_sys)
  begin
    fb_led_q <= fb_led_d;
    ib_led_q <= ib_led_d;
  end

  assign o_fieldbus_led = fb_led_q;
  assign o_ibus_led     = ib_led_q;

  // Local data image, refreshed from the internal bus.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_img_we)
      img_q[i_img_waddr] <= i_img_wdata;
  end

  // Host read answer one cycle after the request.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
    end
    else
    begin
      rvalid_q <= i_host_rd;
      if (i_host_rd)
        rdata_q <= img_q[i_host_raddr];
    end
  end

  assign o_host_rvalid = rvalid_q;
  assign o_host_rdata  = rdata_q;

  // Write gate: permit open or action in the allowed set.
  assign wr_ok = permit || act_allowed(i_host_act);

  // Write acknowledge and forwarding to the internal bus.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      ack_q   <= 1'b0;
      ref_q   <= 1'b0;
      iwr_q   <= 1'b0;
      inode_q <= '0;
      idata_q <= '0;
    end
    else
    begin
      ack_q <= i_host_wr && wr_ok;
      ref_q <= i_host_wr && !wr_ok;
      iwr_q <= i_host_wr && wr_ok;
      if (i_host_wr && wr_ok)
      begin
        inode_q <= i_host_node;
        idata_q <= i_host_wdata;
      end
    end
  end

  assign o_host_wr_ack     = ack_q;
  assign o_host_wr_refused = ref_q;
  assign o_ibus_wr         = iwr_q;
  assign o_ibus_node       = inode_q;
  assign o_ibus_wdata      = idata_q;

endmodule

// ==== bench/bcs_node_model.sv ====
/*
  Internal breaker bus nodes: presence and fault levels, and a log of the
  last write routed to them. Assumes write pulses one clock wide.
*/
`timescale 1ns/1ps
module bcs_node_model
  import bcs_pkg::*;
(
  input  wire logic                    i_clk_sys,    // Clock.
  input  wire logic [1:0]              i_scene,      // Bus population.
  input  wire logic                    i_ibus_wr,    // Write pulse.
  input  wire logic [NODE_W-1:0]       i_ibus_node,  // Target node.
  input  wire logic [IMG_DW-1:0]       i_ibus_wdata, // Write data.
  output logic                         o_fault,      // Bus fault.
  output logic                         o_any,        // Some node found.
  output logic                         o_core,       // Meter or trip unit.
  output logic [NODE_W+IMG_DW-1:0]     o_last        // Last node and data.
);
  // Scene 0 is empty, 1 plain nodes, 2 core node, 3 a faulty bus.
  assign o_fault = (i_scene == 2'h3);
  assign o_any   = (i_scene != 2'h0);
  assign o_core  = (i_scene == 2'h2);

  // The addressed node takes each write whole at the pulse.
  always_ff @(posedge i_clk_sys)
  begin
    if (i_ibus_wr)
      o_last <= {i_ibus_node, i_ibus_wdata};
  end
endmodule

// ==== bench/bcs_status_chk.sv ====
/*
  Port checker for the breaker status block, bound to its top module.
  Assumes one clock, a sync active-high reset and two-stage pin sync.
*/
`timescale 1ns/1ps
module bcs_status_chk
  import bcs_pkg::*;
#(
  parameter longint DIAG_CYCLES = NP_DIAG_CYCLES
)
(
  input wire logic        i_clk_sys,                // Clock.
  input wire logic        i_rst,                    // Reset.
  input wire logic        i_rear_position_switch,   // Pin.
  input wire logic        i_middle_position_switch, // Pin.
  input wire logic        i_front_position_switch,  // Pin.
  input wire logic        i_write_permit_input,     // Pin.
  input wire logic        i_class1_cyclic,          // Class 1 traffic.
  input wire logic        i_ibus_fault,             // Bus fault.
  input wire logic        i_ibus_any_node,          // Node found.
  input wire logic        i_host_rd,                // Read.
  input wire logic        i_host_wr,                // Write.
  input wire bcs_act_type i_host_act,               // Write class.
  input wire bcs_pos_type o_pos,                    // Position.
  input wire logic        o_np_diag,                // Diagnostic.
  input wire bcs_led_type o_fieldbus_led,           // Fieldbus light.
  input wire bcs_led_type o_ibus_led,               // Bus light.
  input wire logic        o_host_rvalid,            // Read answer.
  input wire logic        o_host_wr_ack,            // Write taken.
  input wire logic        o_host_wr_refused,        // Write refused.
  input wire logic        o_ibus_wr                 // Bus write.
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);

  // Counts cycles spent with the position reported as not present.
  logic [31:0] np_cnt_q;
  logic [31:0] np_cnt_d;
  assign np_cnt_d = (o_pos == POS_NOT_PRESENT) ? np_cnt_q + 32'h0000_0001
                                               : 32'h0000_0000;
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      np_cnt_q <= 32'h0000_0000;
    else
      np_cnt_q <= np_cnt_d;
  end

  a_read_answer:
    assert property (i_host_rd |=> o_host_rvalid)
    else $error("host read not answered");
  a_write_answer:
    assert property (i_host_wr |=> (o_host_wr_ack ^ o_host_wr_refused))
    else $error("host write not answered once");
  a_write_blocked:
    assert property (i_host_wr && (i_host_act <= ACT_STARTUP_XFER) &&
      !i_write_permit_input && !$past(i_write_permit_input) &&
      !$past(i_write_permit_input, 2) |=> o_host_wr_refused && !o_ibus_wr)
    else $error("blocked write went through");
  a_write_allowed:
    assert property (i_host_wr && (i_host_act >= ACT_WAVE_TRIG)
      |=> o_host_wr_ack && o_ibus_wr)
    else $error("permitted write not forwarded");
  a_fieldbus_led:
    assert property (o_fieldbus_led ==
      ($past(i_class1_cyclic) ? LED_GREEN : LED_RED))
    else $error("fieldbus light wrong");
  a_ibus_led:
    assert property (($past(i_ibus_fault) || !$past(i_ibus_any_node)) |->
      o_ibus_led == ($past(i_ibus_fault) ? LED_RED : LED_OFF))
    else $error("bus light wrong");
  a_front_release:
    assert property ($fell(i_front_position_switch) &&
      !i_rear_position_switch && !i_middle_position_switch
      |-> ##3 o_pos == POS_NOT_PRESENT)
    else $error("not present late");
  a_diag_early:
    assert property (np_cnt_q < DIAG_CYCLES |-> !o_np_diag)
    else $error("diagnostic raised early");
  a_diag_position:
    assert property (o_np_diag |-> o_pos == POS_NOT_PRESENT)
    else $error("diagnostic without absence");

  c_diag: cover property ($rose(o_np_diag));
  c_refused: cover property (o_host_wr_refused);
  c_forward: cover property (o_ibus_wr);
endmodule

bind bcs_status bcs_status_chk #(.DIAG_CYCLES(DIAG_CYCLES)) i_chk (
  .i_clk_sys, .i_rst, .i_rear_position_switch, .i_middle_position_switch,
  .i_front_position_switch, .i_write_permit_input, .i_class1_cyclic,
  .i_ibus_fault, .i_ibus_any_node, .i_host_rd, .i_host_wr, .i_host_act,
  .o_pos, .o_np_diag, .o_fieldbus_led, .o_ibus_led, .o_host_rvalid,
  .o_host_wr_ack, .o_host_wr_refused, .o_ibus_wr);

// ==== bench/tb.sv ====
/*
  Bench for the breaker status block beside a model of the bus nodes.
  Assumes short diagnostic and flash counts set at the instance.
*/
`timescale 1ns/1ps
module tb;
  import bcs_pkg::*;
  localparam longint DG = 50;
  logic i_clk_sys = 1'h0, i_rst = 1'h1, i_addr_cfg_we = 1'h0;
  logic i_rear_position_switch = 1'h0, i_middle_position_switch = 1'h0;
  logic i_front_position_switch = 1'h0, i_write_permit_input = 1'h0;
  logic i_class1_cyclic = 1'h0, i_img_we = 1'h0, i_host_rd = 1'h0;
  logic i_host_wr = 1'h0, i_ibus_fault, i_ibus_any_node, i_ibus_core_node;
  logic [6:0] i_addr_cfg = 7'h00, o_station_addr;
  logic [7:0] i_img_waddr = 8'h00, i_host_raddr = 8'h00;
  logic [15:0] i_img_wdata = 16'h0000, i_host_wdata = 16'h0000;
  logic [15:0] o_host_rdata, o_ibus_wdata;
  logic [2:0] i_host_node = 3'h0, o_ibus_node;
  logic [1:0] scene = 2'h0;
  logic [18:0] last;
  bcs_act_type i_host_act = ACT_SWITCH;
  bcs_pos_type o_pos;
  bcs_led_type o_fieldbus_led, o_ibus_led;
  logic o_np_diag, o_host_rvalid, o_host_wr_ack, o_host_wr_refused;
  logic o_ibus_wr;
  int mismatches = 0;
  int num_checks = 0;

  // Clock of 50 ns period.
  always #25 i_clk_sys = ~i_clk_sys;

  bcs_status #(.DIAG_CYCLES(DG), .FLASH_CYCLES(8)) i_bcs_status (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_rear_position_switch(i_rear_position_switch),
    .i_middle_position_switch(i_middle_position_switch),
    .i_front_position_switch(i_front_position_switch),
    .i_write_permit_input(i_write_permit_input),
    .i_addr_cfg_we(i_addr_cfg_we), .i_addr_cfg(i_addr_cfg),
    .i_class1_cyclic(i_class1_cyclic), .i_ibus_fault(i_ibus_fault),
    .i_ibus_any_node(i_ibus_any_node),
    .i_ibus_core_node(i_ibus_core_node), .i_img_we(i_img_we),
    .i_img_waddr(i_img_waddr), .i_img_wdata(i_img_wdata),
    .i_host_rd(i_host_rd), .i_host_raddr(i_host_raddr),
    .i_host_wr(i_host_wr), .i_host_act(i_host_act),
    .i_host_node(i_host_node), .i_host_wdata(i_host_wdata),
    .o_pos(o_pos), .o_np_diag(o_np_diag),
    .o_station_addr(o_station_addr),
    .o_fieldbus_led(o_fieldbus_led), .o_ibus_led(o_ibus_led),
    .o_host_rvalid(o_host_rvalid), .o_host_rdata(o_host_rdata),
    .o_host_wr_ack(o_host_wr_ack),
    .o_host_wr_refused(o_host_wr_refused),
    .o_ibus_wr(o_ibus_wr), .o_ibus_node(o_ibus_node),
    .o_ibus_wdata(o_ibus_wdata));
  bcs_node_model i_bcs_node_model (.i_clk_sys(i_clk_sys), .i_scene(scene),
    .i_ibus_wr(o_ibus_wr), .i_ibus_node(o_ibus_node),
    .i_ibus_wdata(o_ibus_wdata), .o_fault(i_ibus_fault),
    .o_any(i_ibus_any_node), .o_core(i_ibus_core_node), .o_last(last));

  // Steps whole cycles and lands just after the edge.
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk_sys);
    #5;
  endtask

  // Counts a comparison and reports a difference.
  task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Sets the switch pins, waits out sync and decode, checks position.
  task automatic sw(input logic [2:0] v, input bcs_pos_type p);
    {i_rear_position_switch, i_middle_position_switch,
      i_front_position_switch} = v;
    tick(4);
    cmp(o_pos, p);
  endtask

  // Issues one host write, checks the answer and what the node got.
  task automatic hw(input int a, input logic ok);
    i_host_wr = 1'h1;
    i_host_act = bcs_act_type'(a);
    i_host_node = a[2:0];
    i_host_wdata = {4'hC, a[3:0], 8'h5A};
    tick(1);
    i_host_wr = 1'h0;
    cmp(o_host_wr_ack, ok);
    cmp(o_host_wr_refused, !ok);
    tick(1);
    if (ok)
      cmp(last, {i_host_node, i_host_wdata});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence of tests.
  initial
  begin
    logic g;
    logic f;
    g = 1'h0;
    f = 1'h0;
    tick(8);
    i_rst = 1'h0;
    tick(1);
    cmp(o_station_addr, 7'h7E);
    cmp(o_pos, POS_NOT_PRESENT);
    i_addr_cfg = 7'h15;
    i_addr_cfg_we = 1'h1;
    tick(1);
    i_addr_cfg_we = 1'h0;
    cmp(o_station_addr, 7'h15);
    $display("test address done");
    sw(3'h4, POS_CONNECTED);
    sw(3'h0, POS_CONNECTED);
    sw(3'h6, POS_CONNECTED);
    sw(3'h2, POS_TEST);
    sw(3'h3, POS_TEST);
    sw(3'h1, POS_DISCONNECTED);
    i_front_position_switch = 1'h0;
    tick(2);
    cmp(o_pos, POS_DISCONNECTED);
    tick(1);
    cmp(o_pos, POS_NOT_PRESENT);
    tick(DG - 10);
    sw(3'h2, POS_TEST);
    tick(DG);
    cmp(o_np_diag, 1'h0);
    sw(3'h1, POS_DISCONNECTED);
    i_front_position_switch = 1'h0;
    tick(3);
    cmp(o_pos, POS_NOT_PRESENT);
    tick(DG - 1);
    cmp(o_np_diag, 1'h0);
    tick(1);
    cmp(o_np_diag, 1'h1);
    sw(3'h4, POS_CONNECTED);
    cmp(o_np_diag, 1'h0);
    $display("test position done");
    for (int i = 0; i < 16; i++)
      hw(i, i > 8);
    i_write_permit_input = 1'h1;
    tick(3);
    hw(0, 1'h1);
    $display("test write permit done");
    i_img_we = 1'h1;
    i_img_waddr = 8'h03;
    i_img_wdata = 16'h1234;
    tick(1);
    i_img_waddr = 8'h04;
    i_img_wdata = 16'hABCD;
    tick(1);
    i_img_we = 1'h0;
    i_host_rd = 1'h1;
    i_host_raddr = 8'h03;
    tick(1);
    i_host_raddr = 8'h04;
    cmp({o_host_rvalid, o_host_rdata}, 17'h1_1234);
    tick(1);
    i_host_rd = 1'h0;
    cmp({o_host_rvalid, o_host_rdata}, 17'h1_ABCD);
    tick(1);
    cmp(o_host_rvalid, 1'h0);
    $display("test image done");
    cmp(o_fieldbus_led, LED_RED);
    i_class1_cyclic = 1'h1;
    tick(1);
    cmp(o_fieldbus_led, LED_GREEN);
    scene = 2'h3;
    tick(1);
    cmp(o_ibus_led, LED_RED);
    scene = 2'h0;
    tick(1);
    cmp(o_ibus_led, LED_OFF);
    scene = 2'h2;
    tick(1);
    cmp(o_ibus_led, LED_GREEN);
    scene = 2'h1;
    repeat (18)
    begin
      tick(1);
      g = g | (o_ibus_led === LED_GREEN);
      f = f | (o_ibus_led === LED_OFF);
    end
    cmp({g, f}, 2'h3);
    $display("test indicators done");
    final_report();
  end

  // Cuts a hang short well past the expected run length.
  initial
  begin
    #(2000 * 50);
    mismatches++;
    final_report();
  end
endmodule
